// ---- core/acoc_dev.sv ----
/*
 * sample fifo and conditioning datapath: input scaling, breakpoint
 * interpolation, noise cancel filter, gain, offset, clamp, supply check.
 * assumes one clock, the acoc_if link and a power-of-two fifo depth.
 */
`timescale 1ns/1ps

// ********************************************************************
// sample fifo
// ********************************************************************
module acoc_fifo
    import acoc_pkg::*;
#(
    parameter int W = 16,
    parameter int D = 8
) (
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         nrst,
    // filling side
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output logic              in_ready,
    // draining side
    output logic              out_valid,
    output logic [W-1:0]      out_data,
    input  wire logic         out_ready
);
    localparam int AW = $clog2(D);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wp;
        logic [AW-1:0]       rp;
        logic [AW:0]         cnt;
    } acoc_fifo_s;

    acoc_fifo_s q;
    acoc_fifo_s d;
    logic       push;
    logic       pop;

    // flags from the occupancy count
    assign in_ready  = (q.cnt != (AW+1)'(D));
    assign out_valid = (q.cnt != '0);
    assign out_data  = q.mem[q.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // pointer and count update
    always_comb begin
        d = q;
        if (push) begin
            d.mem[q.wp] = in_data;
            d.wp        = q.wp + 1'b1;
        end
        if (pop) begin
            d.rp = q.rp + 1'b1;
        end
        d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule

// ********************************************************************
// conditioning datapath end
// ********************************************************************
module acoc_dev
    import acoc_pkg::*;
#(
    parameter int DIV_2K  = `ACOC_CLK_HZ / `ACOC_SPS_2K,
    parameter int DIV_4K  = `ACOC_CLK_HZ / `ACOC_SPS_4K,
    parameter int DIV_8K  = `ACOC_CLK_HZ / `ACOC_SPS_8K,
    parameter int DIV_16K = `ACOC_CLK_HZ / `ACOC_SPS_16K
) (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic nrst,
    // link
    acoc_if.dev       lnk,
    // user side status
    output logic      cfg_locked,
    output logic [1:0] rate_sel,
    output logic [3:0] meas_setup,
    output logic      meas_bad,
    output logic      var_bp
);
    typedef struct packed {
        logic [`ACOC_NREGS-1:0][15:0] cfg;
        acoc_word_t  rdata;
        logic [14:0] tick_cnt;
        logic        tick_pend;
        acoc_state_e st;
        acoc_word_t  smp;
        acoc_word_t  filt;
        logic        out_valid;
        acoc_word_t  out_data;
        logic        uv;
        logic        ov;
    } acoc_dev_s;

    acoc_dev_s  q;
    acoc_dev_s  d;
    logic       fifo_valid;
    acoc_word_t fifo_data;
    logic       fifo_pop;

    // saturate a wide signed result to a 16-bit word
    function automatic acoc_word_t sat16(input logic signed [48:0] v);
        if (v > 49'sh7fff) begin
            sat16 = 16'h7fff;
        end else if (v < -49'sh8000) begin
            sat16 = 16'h8000;
        end else begin
            sat16 = v[15:0];
        end
    endfunction

    // segment index of a signed input among ascending positions
    function automatic logic [1:0] seg_of(input acoc_word_t v,
                                          input logic [3:0][15:0] xs);
        logic [1:0] s;
        s = 2'h0;
        for (int k = 1; k < `ACOC_NSEG; k++) begin
            if ($signed(v) >= $signed(xs[k])) begin
                s = 2'(k);
            end
        end
        return s;
    endfunction

    // fifo of raw samples in front of the datapath
    acoc_fifo #(.W(16), .D(`ACOC_FIFO_DEPTH)) u_fifo (
        .clk_sys   (clk_sys),
        .nrst      (nrst),
        .in_valid  (lnk.smp_valid),
        .in_data   (lnk.smp_data),
        .in_ready  (lnk.smp_ready),
        .out_valid (fifo_valid),
        .out_data  (fifo_data),
        .out_ready (fifo_pop)
    );

    // one sample taken per rate tick, only while idle
    assign fifo_pop = (q.st == ACOC_S_IDLE) && q.tick_pend && fifo_valid;

    // outputs straight from registers
    assign lnk.cfg_rdata = q.rdata;
    assign lnk.out_valid = q.out_valid;
    assign lnk.out_data  = q.out_data;
    assign lnk.uv_flag   = q.uv;
    assign lnk.ov_flag   = q.ov;
    assign cfg_locked    = q.cfg[`ACOC_R_FRONT][`ACOC_F_LOCK];
    assign rate_sel      = q.cfg[`ACOC_R_FRONT][`ACOC_F_RATE];
    assign meas_setup    = q.cfg[`ACOC_R_FRONT][`ACOC_F_MEAS];
    assign meas_bad      = q.cfg[`ACOC_R_FRONT][`ACOC_F_MEASTOP];
    assign var_bp        = q.cfg[`ACOC_R_PATH][`ACOC_F_VARBP];

    // configuration, tick, datapath sequencer
    always_comb begin
        logic [14:0]       div;
        logic [2:0]        mult;
        logic [18:0]       wrap;
        logic signed [48:0] acc;
        logic signed [16:0] dif;
        logic [16:0]       mag;
        logic [3:0][15:0]  xs;
        logic [1:0]        sg;
        acoc_word_t        thr;
        acoc_word_t        att;
        d    = q;
        div  = 15'h0;
        mult = 3'h1;
        wrap = '0;
        acc  = '0;
        dif  = '0;
        mag  = '0;
        xs   = '0;
        sg   = 2'h0;
        thr  = {8'h00, q.cfg[`ACOC_R_NOISE][`ACOC_F_THR]};
        att  = {8'h00, q.cfg[`ACOC_R_NOISE][`ACOC_F_ATT]};
        d.out_valid = 1'b0;
        // register writes refused once locked
        if (lnk.cfg_wr && !cfg_locked
            && (lnk.cfg_addr < 5'(`ACOC_NREGS))) begin
            d.cfg[lnk.cfg_addr] = lnk.cfg_wdata;
        end
        // read data with live status word
        if (lnk.cfg_addr == `ACOC_R_STATUS) begin
            d.rdata = {12'h000, meas_bad, cfg_locked, q.ov, q.uv};
        end else if (lnk.cfg_addr < 5'(`ACOC_NREGS)) begin
            d.rdata = q.cfg[lnk.cfg_addr];
        end else begin
            d.rdata = 16'h0000;
        end
        // sample rate divider
        case (rate_sel)
            2'b00:   div = 15'(DIV_2K - 1);
            2'b01:   div = 15'(DIV_4K - 1);
            2'b10:   div = 15'(DIV_8K - 1);
            default: div = 15'(DIV_16K - 1);
        endcase
        // pop clears first so a tick in the same cycle is kept
        if (fifo_pop) begin
            d.tick_pend = 1'b0;
        end
        if (q.tick_cnt >= div) begin
            d.tick_cnt  = 15'h0;
            d.tick_pend = 1'b1;
        end else begin
            d.tick_cnt = q.tick_cnt + 15'h1;
        end
        // breakpoint positions, fixed or programmable
        if (var_bp) begin
            for (int k = 0; k < `ACOC_NSEG; k++) begin
                xs[k] = q.cfg[`ACOC_R_BPX0 + k];
            end
        end else begin
            xs = {`ACOC_FIX_X3, `ACOC_FIX_X2, `ACOC_FIX_X1, `ACOC_FIX_X0};
        end
        case (q.st)
            ACOC_S_IDLE: begin
                if (fifo_pop) begin
                    // angle wrap: repeat the range by a whole factor
                    case (q.cfg[`ACOC_R_FRONT][`ACOC_F_MODULO])
                        2'b00:   mult = 3'h1;
                        2'b01:   mult = 3'h4;
                        2'b10:   mult = 3'h3;
                        default: mult = 3'h2;
                    endcase
                    wrap  = fifo_data * mult;
                    d.smp = wrap[15:0];
                    d.st  = ACOC_S_SCALE;
                end
            end
            ACOC_S_SCALE: begin
                acc = 49'($signed(q.smp)) *
                      49'($signed(q.cfg[`ACOC_R_INGAIN]));
                acc = (acc <<< q.cfg[`ACOC_R_PATH][`ACOC_F_NMULT])
                      >>> `ACOC_FRAC_IN;
                d.smp = sat16(acc);
                d.st  = ACOC_S_LIN;
            end
            ACOC_S_LIN: begin
                sg  = seg_of(q.smp, xs);
                dif = $signed({q.smp[15], q.smp})
                      - $signed({xs[sg][15], xs[sg]});
                acc = 49'(dif) * 49'($signed(q.cfg[`ACOC_R_SLOPE0 + sg]));
                acc = (acc <<< q.cfg[`ACOC_R_PATH][`ACOC_F_NSLOPE])
                      >>> `ACOC_FRAC_IN;
                acc = acc + 49'($signed(q.cfg[`ACOC_R_BPY0 + sg]));
                d.smp = sat16(acc);
                d.st  = ACOC_S_NC;
            end
            ACOC_S_NC: begin
                dif = $signed({q.smp[15], q.smp})
                      - $signed({q.filt[15], q.filt});
                mag = dif[16] ? 17'(-dif) : 17'(dif);
                if ((thr == 16'h0000 && att == 16'h0000)
                    || (mag >= {1'b0, thr})) begin
                    d.filt = q.smp;
                end else begin
                    acc = (49'(dif) * 49'($signed({1'b0, att})))
                          >>> `ACOC_FRAC_NC;
                    acc = acc + 49'($signed(q.filt));
                    d.filt = sat16(acc);
                end
                d.st = ACOC_S_GAIN;
            end
            ACOC_S_GAIN: begin
                acc = (49'($signed(q.filt)) *
                       49'($signed(q.cfg[`ACOC_R_GAIN]))) >>> `ACOC_FRAC_OUT;
                acc = acc + 49'($signed(q.cfg[`ACOC_R_OFFSET]));
                d.smp = sat16(acc);
                d.st  = ACOC_S_CLAMP;
            end
            ACOC_S_CLAMP: begin
                d.out_data = q.smp;
                if ($signed(q.smp) < $signed(q.cfg[`ACOC_R_LOWER])) begin
                    d.out_data = q.cfg[`ACOC_R_LOWER];
                end
                if ($signed(q.smp) > $signed(q.cfg[`ACOC_R_UPPER])) begin
                    d.out_data = q.cfg[`ACOC_R_UPPER];
                end
                d.out_valid = 1'b1;
                d.uv = lnk.sup_level
                       < q.cfg[`ACOC_R_SUPPLY][`ACOC_F_UV];
                d.ov = lnk.sup_level
                       > q.cfg[`ACOC_R_SUPPLY][`ACOC_F_OV];
                d.st = ACOC_S_IDLE;
            end
            default: d.st = ACOC_S_IDLE;
        endcase
    end

    // state register with documented reset values
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            q                       <= '0;
            q.cfg[`ACOC_R_GAIN]     <= `ACOC_RST_GAIN;
            q.cfg[`ACOC_R_UPPER]    <= `ACOC_RST_UPPER;
            q.cfg[`ACOC_R_INGAIN]   <= `ACOC_RST_GAIN;
            q.st                    <= ACOC_S_IDLE;
        end else begin
            q <= d;
        end
    end
endmodule

// ---- shared/acoc_map.svh ----
/*
 * constant map of the angle output conditioning block: register
 * indices, field positions, reset values and timing figures.
 * assumes inclusion by bare name from the package, ahead of the modules.
 */
`ifndef ACOC_MAP_SVH
`define ACOC_MAP_SVH

// ********************************************************************
// register indices, field positions, values and timing
// ********************************************************************
`define ACOC_R_NOISE    5'h00
`define ACOC_R_OFFSET   5'h01
`define ACOC_R_GAIN     5'h02
`define ACOC_R_LOWER    5'h03
`define ACOC_R_UPPER    5'h04
`define ACOC_R_SUPPLY   5'h05
`define ACOC_R_FRONT    5'h06
`define ACOC_R_PATH     5'h07
`define ACOC_R_INGAIN   5'h08
`define ACOC_R_BPX0     5'h09
`define ACOC_R_BPY0     5'h0d
`define ACOC_R_SLOPE0   5'h11
`define ACOC_R_STATUS   5'h15
`define ACOC_NREGS      21
`define ACOC_NSEG       4
`define ACOC_F_THR      15:8
`define ACOC_F_ATT      7:0
`define ACOC_F_OV       15:8
`define ACOC_F_UV       7:0
`define ACOC_F_LOCK     15
`define ACOC_F_FRZERO   14:8
`define ACOC_F_MODULO   7:6
`define ACOC_F_RATE     5:4
`define ACOC_F_MEAS     3:0
`define ACOC_F_MEASTOP  3
`define ACOC_F_PTRSV    15:8
`define ACOC_F_NMULT    7:5
`define ACOC_F_NSLOPE   4:1
`define ACOC_F_VARBP    0
`define ACOC_RST_GAIN   16'h4000
`define ACOC_RST_UPPER  16'h7fff
`define ACOC_FRAC_IN    15
`define ACOC_FRAC_OUT   14
`define ACOC_FRAC_NC    8
`define ACOC_ATT_MAX    8'h80
`define ACOC_FIX_X0     16'h8000
`define ACOC_FIX_X1     16'hc000
`define ACOC_FIX_X2     16'h0000
`define ACOC_FIX_X3     16'h4000
`define ACOC_CLK_HZ     40000000
`define ACOC_SPS_2K     2000
`define ACOC_SPS_4K     4000
`define ACOC_SPS_8K     8000
`define ACOC_SPS_16K    16000
`define ACOC_FIFO_DEPTH 8

`endif

// ---- shared/acoc_pkg.sv ----
/*
 * types shared by both ends of the angle output conditioning block.
 * assumes the constant map is on the include path.
 */
`include "acoc_map.svh"

package acoc_pkg;

    // ****************************************************************
    // datapath sequencer states
    // ****************************************************************
    typedef enum logic [2:0] {
        ACOC_S_IDLE  = 3'b000,
        ACOC_S_SCALE = 3'b001,
        ACOC_S_LIN   = 3'b010,
        ACOC_S_NC    = 3'b011,
        ACOC_S_GAIN  = 3'b100,
        ACOC_S_CLAMP = 3'b101
    } acoc_state_e;

    typedef logic [15:0] acoc_word_t;

endpackage

// ---- shared/acoc_if.sv ----
/*
 * link between the conditioning datapath and its configuring party:
 * configuration port, sample stream, output stream, supply levels.
 * assumes one clock shared by both ends.
 */
`timescale 1ns/1ps

interface acoc_if (
    // clock
    input wire logic clk_sys
);
    import acoc_pkg::*;

    // configuration port
    logic       cfg_wr;
    logic [4:0] cfg_addr;
    acoc_word_t cfg_wdata;
    acoc_word_t cfg_rdata;
    // raw angle samples
    logic       smp_valid;
    acoc_word_t smp_data;
    logic       smp_ready;
    // conditioned output
    logic       out_valid;
    acoc_word_t out_data;
    // supply supervision
    logic [7:0] sup_level;
    logic       uv_flag;
    logic       ov_flag;

    modport dev (
        input  cfg_wr, cfg_addr, cfg_wdata, smp_valid, smp_data,
               sup_level,
        output cfg_rdata, smp_ready, out_valid, out_data, uv_flag, ov_flag
    );

    modport host (
        output cfg_wr, cfg_addr, cfg_wdata, smp_valid, smp_data,
               sup_level,
        input  cfg_rdata, smp_ready, out_valid, out_data, uv_flag, ov_flag
    );

endinterface

// ---- core/acoc_host.sv ----
/*
 * configuring party end: sanitises register writes, feeds raw
 * samples into the link and returns conditioned output and flags.
 * assumes one clock and the acoc_if link.
 */
`timescale 1ns/1ps

module acoc_host
    import acoc_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    // link
    acoc_if.host             lnk,
    // user configuration requests
    input  wire logic        usr_wr,
    input  wire logic [4:0]  usr_addr,
    input  wire logic [15:0] usr_wdata,
    output logic [15:0]      usr_rdata,
    output logic             usr_refused,
    // user sample source
    input  wire logic        usr_smp_valid,
    input  wire logic [15:0] usr_smp_data,
    output logic             usr_smp_ready,
    // user output sink and supply
    input  wire logic [7:0]  usr_sup,
    output logic             usr_out_valid,
    output logic [15:0]      usr_out_data,
    output logic             usr_uv,
    output logic             usr_ov
);
    typedef struct packed {
        logic       wr;
        logic [4:0] addr;
        acoc_word_t wdata;
        acoc_word_t rdata;
        logic       refused;
        logic       smp_valid;
        acoc_word_t smp_data;
        logic       smp_ready;
        logic [7:0] sup;
        logic       out_valid;
        acoc_word_t out_data;
        logic       uv;
        logic       ov;
    } acoc_host_s;

    acoc_host_s q;
    acoc_host_s d;

    // outputs straight from registers
    assign lnk.cfg_wr    = q.wr;
    assign lnk.cfg_addr  = q.addr;
    assign lnk.cfg_wdata = q.wdata;
    assign lnk.smp_valid = q.smp_valid;
    assign lnk.smp_data  = q.smp_data;
    assign lnk.sup_level = q.sup;
    assign usr_rdata     = q.rdata;
    assign usr_refused   = q.refused;
    assign usr_smp_ready = q.smp_ready;
    assign usr_out_valid = q.out_valid;
    assign usr_out_data  = q.out_data;
    assign usr_uv        = q.uv;
    assign usr_ov        = q.ov;

    // write sanitising, sample slot, return path
    always_comb begin
        acoc_word_t w;
        d         = q;
        w         = usr_wdata;
        d.wr      = 1'b0;
        d.refused = 1'b0;
        d.addr    = usr_addr;
        if (usr_wr) begin
            if (usr_addr == `ACOC_R_FRONT) begin
                w[`ACOC_F_FRZERO] = '0;
            end
            if (usr_addr == `ACOC_R_PATH) begin
                w[`ACOC_F_PTRSV] = '0;
            end
            if (usr_addr == `ACOC_R_NOISE
                && w[`ACOC_F_ATT] > `ACOC_ATT_MAX) begin
                w[`ACOC_F_ATT] = `ACOC_ATT_MAX;
            end
            d.wdata = w;
            if (usr_addr == `ACOC_R_FRONT && w[`ACOC_F_MEASTOP]) begin
                d.refused = 1'b1;
            end else begin
                d.wr = 1'b1;
            end
        end
        d.rdata = lnk.cfg_rdata;
        // one-word slot toward the device fifo
        if (q.smp_valid && lnk.smp_ready) begin
            d.smp_valid = 1'b0;
        end
        if (usr_smp_valid && q.smp_ready) begin
            d.smp_valid = 1'b1;
            d.smp_data  = usr_smp_data;
        end
        d.smp_ready = !d.smp_valid;
        d.sup       = usr_sup;
        d.out_valid = lnk.out_valid;
        d.out_data  = lnk.out_data;
        d.uv        = lnk.uv_flag;
        d.ov        = lnk.ov_flag;
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            q           <= '0;
            q.smp_ready <= 1'b1;
        end else begin
            q <= d;
        end
    end
endmodule

// ---- testbench/acoc_properties.sv ----
/*
 * link checker for the conditioning pair: write-back, lock, limits,
 * supply flags, output spacing and host side sanitising.
 * assumes the testbench instantiates it beside the shared link.
 */
`timescale 1ns/1ps

module acoc_props
    import acoc_pkg::*;
(
    // clock and reset
    input wire logic       clk_sys,
    input wire logic       nrst,
    // link signals
    input wire logic       cfg_wr,
    input wire logic [4:0] cfg_addr,
    input wire acoc_word_t cfg_wdata,
    input wire acoc_word_t cfg_rdata,
    input wire logic       out_valid,
    input wire acoc_word_t out_data,
    input wire logic [7:0] sup_level,
    input wire logic       uv_flag,
    input wire logic       ov_flag
);
    // ****************************************************************
    // shadow of written fields, then properties
    // ****************************************************************
    logic       lk_q;
    acoc_word_t lo_q;
    acoc_word_t hi_q;
    acoc_word_t sup_q;
    wire logic  take = cfg_wr && !lk_q && (cfg_addr < 5'h15);

    // track accepted writes
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            lk_q <= 1'b0;
            lo_q <= 16'h0000;
            hi_q <= 16'h7fff;
            sup_q <= 16'h0000;
        end else begin
            if (take && cfg_addr == 5'h06) lk_q <= cfg_wdata[15];
            if (take && cfg_addr == 5'h03) lo_q <= cfg_wdata;
            if (take && cfg_addr == 5'h04) hi_q <= cfg_wdata;
            if (take && cfg_addr == 5'h05) sup_q <= cfg_wdata;
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    sequence s_settle;
        !cfg_wr && $stable(cfg_addr);
    endsequence

    property p_wr_rd;
        !lk_q && cfg_wr && cfg_addr inside {[5'h01:5'h04]} ##1 s_settle
        |=> cfg_rdata == $past(cfg_wdata, 2);
    endproperty
    a_wr_rd: assert property (p_wr_rd)
        else $error("write not read back");

    property p_lock;
        lk_q && cfg_wr ##1 s_settle |=> cfg_rdata == $past(cfg_rdata);
    endproperty
    a_lock: assert property (p_lock)
        else $error("write taken while locked");

    property p_uv;
        out_valid |-> uv_flag == ($past(sup_level) < sup_q[7:0]);
    endproperty
    a_uv: assert property (p_uv)
        else $error("undervoltage flag wrong");

    property p_ov;
        out_valid |-> ov_flag == ($past(sup_level) > sup_q[15:8]);
    endproperty
    a_ov: assert property (p_ov)
        else $error("overvoltage flag wrong");

    property p_clamp;
        out_valid |-> $signed(out_data) <= $signed(hi_q)
            && ($signed(lo_q) > $signed(hi_q)
            || $signed(out_data) >= $signed(lo_q));
    endproperty
    a_clamp: assert property (p_clamp)
        else $error("output outside limits");

    property p_out_gap;
        out_valid |=> !out_valid [*5];
    endproperty
    a_out_gap: assert property (p_out_gap)
        else $error("outputs too close");

    property p_front;
        cfg_wr && cfg_addr == 5'h06 |-> cfg_wdata[14:8] == 7'h00;
    endproperty
    a_front: assert property (p_front)
        else $error("front reserved bits set");

    property p_meas;
        cfg_wr && cfg_addr == 5'h06 |-> !cfg_wdata[3];
    endproperty
    a_meas: assert property (p_meas)
        else $error("forbidden setup code sent");

    property p_factor;
        cfg_wr && cfg_addr == 5'h00 |-> cfg_wdata[7:0] <= 8'h80;
    endproperty
    a_factor: assert property (p_factor)
        else $error("filter factor too large");
endmodule

// ---- testbench/acoc_tb_top.sv ----
/*
 * testbench of the conditioning pair: table of output cases, then
 * filter, fifo, refusal and lock cases.
 * assumes the shared package, link and both ends compiled before.
 */
`timescale 1ns/1ps

module acoc_tb_top;
    import acoc_pkg::*;

    typedef struct packed {
        acoc_word_t g, off, lo, hi, smp, res;
        logic [7:0] sup;
        logic       uv, ov;
    } acoc_row_s;

    // gain, offset, limits, sample, result, supply, flags
    localparam acoc_row_s ROWS [6] = '{
        '{16'h4000, 16'h0000, 16'h0000, 16'h7fff, 16'h1000, 16'h1000,
          8'h10, 1'b1, 1'b0},
        '{16'h4000, 16'h0010, 16'h0000, 16'h7fff, 16'h5000, 16'h2010,
          8'h50, 1'b0, 1'b0},
        '{16'hc000, 16'h3000, 16'h0000, 16'h7fff, 16'h1000, 16'h2000,
          8'h90, 1'b0, 1'b1},
        '{16'h8000, 16'h0000, 16'h0000, 16'h7fff, 16'h5000, 16'h0000,
          8'h20, 1'b0, 1'b0},
        '{16'h4000, 16'h0000, 16'h0000, 16'h1800, 16'h5000, 16'h1800,
          8'h80, 1'b0, 1'b0},
        '{16'h7fff, 16'h7000, 16'h0000, 16'h7fff, 16'h5000, 16'h7fff,
          8'h81, 1'b0, 1'b1}};

    logic       clk_sys, nrst, usr_wr, usr_smp_valid, saw_full;
    logic       usr_refused, usr_smp_ready, usr_out_valid, usr_uv, usr_ov;
    logic       cfg_locked, meas_bad, var_bp;
    logic [1:0] rate_sel;
    logic [3:0] meas_setup;
    logic [4:0] usr_addr;
    logic [7:0] usr_sup;
    acoc_word_t usr_wdata, usr_rdata, usr_smp_data, usr_out_data;
    int         n_fail, checks, n_out, n_ref;

    // ****************************************************************
    // the pair, the checker, clock, monitors, tasks
    // ****************************************************************
    acoc_if acoc_if_i (.clk_sys(clk_sys));
    acoc_dev #(.DIV_2K(40), .DIV_4K(20), .DIV_8K(10), .DIV_16K(5))
    acoc_dev_i (.clk_sys, .nrst, .lnk(acoc_if_i.dev), .cfg_locked,
        .rate_sel, .meas_setup, .meas_bad, .var_bp);
    acoc_host acoc_host_i (.clk_sys, .nrst, .lnk(acoc_if_i.host), .usr_wr,
        .usr_addr, .usr_wdata, .usr_rdata, .usr_refused, .usr_smp_valid,
        .usr_smp_data, .usr_smp_ready, .usr_sup, .usr_out_valid,
        .usr_out_data, .usr_uv, .usr_ov);
    acoc_props acoc_props_i (.clk_sys, .nrst,
        .cfg_wr(acoc_if_i.cfg_wr), .cfg_addr(acoc_if_i.cfg_addr),
        .cfg_wdata(acoc_if_i.cfg_wdata), .cfg_rdata(acoc_if_i.cfg_rdata),
        .out_valid(acoc_if_i.out_valid), .out_data(acoc_if_i.out_data),
        .sup_level(acoc_if_i.sup_level), .uv_flag(acoc_if_i.uv_flag),
        .ov_flag(acoc_if_i.ov_flag));

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // count outputs, refusals and a full fifo
    always @(posedge clk_sys) begin
        if (usr_out_valid === 1'b1) n_out++;
        if (usr_refused === 1'b1) n_ref++;
        if (acoc_if_i.smp_ready === 1'b0) saw_full = 1'b1;
    end

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic cmpw(input string nm, input acoc_word_t e, g);
        checks++;
        if (g !== e) begin
            $display("wrong value %s: expected %h, seen %h", nm, e, g);
            n_fail++;
        end
    endtask

    task automatic cmpb(input string nm, input logic e, g);
        checks++;
        if (g !== e) begin
            $display("wrong value %s: expected %b, seen %b", nm, e, g);
            n_fail++;
        end
    endtask

    // write pulse, then let the register settle
    task automatic wr(input logic [4:0] a, input acoc_word_t d);
        @(negedge clk_sys);
        usr_wr = 1'b1;
        usr_addr = a;
        usr_wdata = d;
        @(negedge clk_sys);
        usr_wr = 1'b0;
        repeat (2) @(negedge clk_sys);
    endtask

    task automatic rd(input logic [4:0] a, output acoc_word_t d);
        @(negedge clk_sys);
        usr_addr = a;
        repeat (4) @(negedge clk_sys);
        d = usr_rdata;
    endtask

    // hold the sample until the host takes it
    task automatic smp(input acoc_word_t x);
        int i;
        @(negedge clk_sys);
        usr_smp_valid = 1'b1;
        usr_smp_data = x;
        i = 0;
        while (usr_smp_ready !== 1'b1) begin
            if (i++ > 200) begin n_fail++; give_verdict(); end
            @(negedge clk_sys);
        end
        @(negedge clk_sys);
        usr_smp_valid = 1'b0;
    endtask

    task automatic chk_smp(input acoc_word_t x, e);
        int i;
        smp(x);
        i = 0;
        while (usr_out_valid !== 1'b1) begin
            if (i++ > 400) begin n_fail++; give_verdict(); end
            @(negedge clk_sys);
        end
        cmpw("out", e, usr_out_data);
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        acoc_word_t d;
        int         base;
        {nrst, usr_wr, usr_smp_valid, saw_full} = 4'h0;
        {usr_addr, usr_wdata, usr_smp_data, usr_sup} = '0;
        {n_fail, checks, n_out, n_ref} = '0;
        repeat (3) @(negedge clk_sys);
        nrst = 1'b1;
        rd(5'h02, d);
        cmpw("gain reset", 16'h4000, d);
        rd(5'h04, d);
        cmpw("upper reset", 16'h7fff, d);
        wr(5'h07, 16'h0021);
        cmpb("var_bp", 1'b1, var_bp);
        wr(5'h07, 16'h0020);
        cmpb("var_bp", 1'b0, var_bp);
        wr(5'h0f, 16'h1000);
        wr(5'h10, 16'h2000);
        wr(5'h05, 16'h8020);
        wr(5'h06, 16'h0030);
        cmpw("rate", 16'h0003, 16'(rate_sel));
        foreach (ROWS[k]) begin
            wr(5'h02, ROWS[k].g);
            wr(5'h01, ROWS[k].off);
            wr(5'h03, ROWS[k].lo);
            wr(5'h04, ROWS[k].hi);
            usr_sup = ROWS[k].sup;
            chk_smp(ROWS[k].smp, ROWS[k].res);
            cmpb("uv", ROWS[k].uv, usr_uv);
            cmpb("ov", ROWS[k].ov, usr_ov);
        end
        wr(5'h02, 16'h4000);
        wr(5'h01, 16'h0000);
        wr(5'h00, 16'hffff);
        rd(5'h00, d);
        cmpw("factor", 16'hff80, d);
        chk_smp(16'h1000, 16'h1000);
        wr(5'h0f, 16'h1064);
        chk_smp(16'h1000, 16'h1032);
        wr(5'h00, 16'h0000);
        chk_smp(16'h1000, 16'h1064);
        wr(5'h06, 16'h0000);
        base = n_out;
        repeat (12) smp(16'h1000);
        for (int i = 0; i < 2000 && n_out < base + 12; i++)
            @(negedge clk_sys);
        cmpw("outputs", 16'h000c, 16'(n_out - base));
        cmpb("fifo full", 1'b1, saw_full);
        wr(5'h13, 16'h4000);
        wr(5'h07, 16'h0022);
        chk_smp(16'h1000, 16'h2064);
        wr(5'h06, 16'h0038);
        cmpw("refused", 16'h0001, 16'(n_ref));
        cmpw("meas", 16'h0000, {11'h0, meas_bad, meas_setup});
        rd(5'h16, d);
        cmpw("unmapped", 16'h0000, d);
        wr(5'h06, 16'h8030);
        wr(5'h02, 16'h1234);
        rd(5'h02, d);
        cmpw("locked gain", 16'h4000, d);
        cmpb("lock", 1'b1, cfg_locked);
        give_verdict();
    end
endmodule
